// ==== common/spigot_pkg.sv ====
// Constants and carrier types shared by the e digit spigot engine.
package spigot_pkg;

   // Build-time digit count and the derived store and pass sizes.
   localparam int DIGITS = 31;
   localparam int LOCS = DIGITS + 1;
   localparam int PASSES = DIGITS - 1;

   // A cell never holds more than its divisor, at most LOCS + 1, so six bits suffice.
   localparam int CELL_W = 6;
   localparam int QUO_W = 5;
   localparam int X_W = 10;
   localparam int PASS_W = 5;

   localparam logic [CELL_W-1:0] CELL_INIT = 6'h01;
   localparam logic [X_W-1:0] STEP_MULT = 10'h00A;
   localparam logic [CELL_W-1:0] DIV_TOP = 6'h21;
   localparam logic [CELL_W-1:0] DIV_LAST = 6'h02;
   localparam logic [PASS_W-1:0] PASS_LAST = 5'h1D;
   localparam logic [3:0] LEAD_DIGIT = 4'h2;
   localparam logic [7:0] BIDIR_OE_ALL = 8'hFF;
   localparam logic [15:0] LANES_RESET = 16'h0000;

   // One BCD digit lane pair, low nibble first in arrival order.
   typedef struct packed {
      logic [3:0] hi;
      logic [3:0] lo;
   } lane_pair_type;

   // All four display lanes: the bidirectional byte holds the newest two.
   typedef struct packed {
      lane_pair_type far_pair;
      lane_pair_type near_pair;
   } lanes_type;

   typedef enum logic [1:0] {
      ST_LEAD = 2'b00,
      ST_STEP = 2'b01,
      ST_EMIT = 2'b10,
      ST_DONE = 2'b11
   } engine_state_type;

endpackage

// ==== src/digit_skid_buffer.sv ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
module digit_skid_buffer
   import spigot_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);

   logic [WIDTH-1:0] slot_r [2];
   logic [1:0] count_r;
   logic rd_ptr_r;
   logic wr_ptr_r;

   wire push = i_ce && i_in_valid && (count_r != 2'h2);
   wire pop = i_ce && i_out_ready && (count_r != 2'h0);

   assign o_in_ready = (count_r != 2'h2);
   assign o_out_valid = (count_r != 2'h0);
   assign o_out_data = slot_r[rd_ptr_r];

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         count_r <= 2'h0;
         rd_ptr_r <= 1'b0;
         wr_ptr_r <= 1'b0;
      end else begin
         if (push) begin
            slot_r[wr_ptr_r] <= i_in_data;
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_r + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule

// ==== src/e_digit_spigot_engine.sv ====
// Spigot engine that streams the decimal digits of e onto four BCD lanes.
//
// Behaviour
// (R1) The engine produces a fixed, build-time count of digits of e, thirty-one in this build.
// (R2) The working store holds one more cell than the digit count.
// (R3) Each digit pass takes one step per cell, there are digit-count minus one passes, and the leading 2 is emitted without a pass.
// (R4) Every step multiplies by a constant, adds the carry and divides giving quotient and remainder.
// (R5) Digits leave one at a time, and a new pass begins only after the previous digit is handed on.
// (R6) Each cell is only as wide as the logarithm of the digit count requires.
// (R7) One shared step unit serves every cell and every pass.
// (R8) Step intermediates live only in combinational wires and never enter the store.
// (R9) Cells are visited strictly in order, each read and written back before moving on.
// (R10) The store is a ring of gated shift registers rotating one place per step, without address decode.
// (R11) Digits are shown in BCD on both the output byte and the bidirectional byte.
// (R12) The bidirectional byte carries lanes 0 and 1 low nibble first, the output byte lanes 2 and 3, and its pins are off until an i_ce edge after reset.
// (R13) A new digit enters lane 0 while older ones move one lane on, and reset reloads the store and restarts.
`timescale 1ns/10ps
module e_digit_spigot_engine
   import spigot_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_pause,
   output logic [7:0] o_out,
   output logic [7:0] o_bidir_out,
   output logic [7:0] o_bidir_oe,
   output logic o_done
);

   // Ring store: cell 0 is always the one under the step unit.
   logic [CELL_W-1:0] ring_r [LOCS]; // [R2] [R6]
   logic [QUO_W-1:0] carry_r;
   logic [CELL_W-1:0] div_r;
   logic [PASS_W-1:0] pass_r;
   engine_state_type state_r;
   logic [3:0] digit_r;
   lanes_type lanes_r;
   logic [7:0] bidir_oe_r;
   logic done_r;

   // Shared step unit; its wires are the only place intermediates exist.
   wire [X_W-1:0] step_x = X_W'(ring_r[0]) * STEP_MULT + X_W'(carry_r); // [R4] [R7] [R8]

   // Restoring divider, one stage per dividend bit, so the divide depth stays fixed and small.
   // Every partial remainder is below the divisor, so one extra bit holds the doubled value.
   wire [CELL_W:0] part_rem [X_W+1];
   wire [X_W-1:0] step_quo;
   wire [CELL_W:0] step_rem;
   wire [CELL_W+1:0] div_ext = {2'h0, div_r};

   assign part_rem[X_W] = '0;

   genvar b;
   generate
      for (b = 0; b < X_W; b++) begin : g_div
         wire [CELL_W+1:0] trial = {part_rem[b+1], step_x[b]};
         wire fits = (trial >= div_ext);
         wire [CELL_W+1:0] diff = trial - div_ext;
         assign step_quo[b] = fits; // [R4]
         assign part_rem[b] = fits ? diff[CELL_W:0] : trial[CELL_W:0]; // [R4]
      end
   endgenerate

   assign step_rem = part_rem[0];
   wire [CELL_W-1:0] cell_new = step_rem[CELL_W-1:0];
   wire [QUO_W-1:0] carry_new = step_quo[QUO_W-1:0];

   wire in_lead = (state_r == ST_LEAD);
   wire in_step = (state_r == ST_STEP);
   wire in_emit = (state_r == ST_EMIT);
   wire do_step = i_ce && in_step;
   wire last_step = (div_r == DIV_LAST);
   wire last_pass = (pass_r == PASS_LAST);

   // Buffer between the engine and the display lanes.
   logic buf_in_ready;
   logic buf_out_valid;
   logic [3:0] buf_out_data;
   wire buf_in_valid = in_lead || in_emit;
   wire [3:0] buf_in_data = in_lead ? LEAD_DIGIT : digit_r;
   wire handed = i_ce && buf_in_valid && buf_in_ready;
   wire lanes_take = i_ce && buf_out_valid && !i_pause;

   digit_skid_buffer #(
      .WIDTH(4)
   ) u_buf (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_in_valid(buf_in_valid),
      .o_in_ready(buf_in_ready),
      .i_in_data(buf_in_data),
      .o_out_valid(buf_out_valid),
      .i_out_ready(!i_pause),
      .o_out_data(buf_out_data)
   );

   // Each cell shifts toward the head; the tail takes the freshly written value.
   // Only the head is ever read, which is why no address decoder is needed.
   wire [CELL_W-1:0] ring_nxt [LOCS];

   genvar k;
   generate
      for (k = 0; k < LOCS; k++) begin : g_ring
         if (k == LOCS - 1) begin : g_tail
            assign ring_nxt[k] = cell_new; // [R9] [R10]
         end else begin : g_body
            assign ring_nxt[k] = ring_r[k+1]; // [R10]
         end
         always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
               ring_r[k] <= CELL_INIT; // [R13]
            end else if (do_step) begin
               ring_r[k] <= ring_nxt[k]; // [R10]
            end
         end
      end
   endgenerate

   // Sequencer: one digit fully handed on before the next pass starts.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_r <= ST_LEAD; // [R13]
         carry_r <= '0;
         div_r <= DIV_TOP;
         pass_r <= '0;
         digit_r <= 4'h0;
         done_r <= 1'b0;
      end else if (i_ce) begin
         unique case (state_r)
            ST_LEAD: begin
               if (handed) begin
                  state_r <= ST_STEP; // [R3]
               end
            end
            ST_STEP: begin
               carry_r <= carry_new;
               div_r <= div_r - 6'h01; // [R3] [R9]
               if (last_step) begin
                  digit_r <= carry_new[3:0];
                  state_r <= ST_EMIT;
               end
            end
            ST_EMIT: begin
               if (handed) begin // [R5]
                  carry_r <= '0;
                  div_r <= DIV_TOP;
                  pass_r <= pass_r + 5'h01;
                  if (last_pass) begin
                     state_r <= ST_DONE; // [R1] [R3]
                     done_r <= 1'b1;
                  end else begin
                     state_r <= ST_STEP;
                  end
               end
            end
            ST_DONE: begin
               done_r <= 1'b1;
            end
         endcase
      end
   end

   // A pause freezes the lanes; the buffer then fills and stalls the sequencer.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         lanes_r <= LANES_RESET;
         bidir_oe_r <= 8'h00;
      end else if (i_ce) begin
         bidir_oe_r <= BIDIR_OE_ALL; // [R12]
         if (lanes_take) begin
            lanes_r <= {lanes_r[11:0], buf_out_data}; // [R13]
         end
      end
   end

   assign o_bidir_out = lanes_r.near_pair; // [R11] [R12]
   assign o_out = lanes_r.far_pair; // [R11] [R12]
   assign o_bidir_oe = bidir_oe_r;
   assign o_done = done_r;

endmodule

// ==== testbench/e_spigot_chk_sva.sv ====
// Port checker for the e digit spigot engine.
`timescale 1ns/10ps
module e_spigot_chk (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_pause,
   input wire logic [7:0] o_out,
   input wire logic [7:0] o_bidir_out,
   input wire logic [7:0] o_bidir_oe,
   input wire logic o_done
);
   wire [15:0] lanes = {o_out, o_bidir_out};
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   chk_reset_clear: assert property (disable iff (1'b0)
      i_rst |=> !lanes && !o_bidir_oe && !o_done) else $error("reset kept state");
   chk_pins_driven: assert property (i_ce |=> o_bidir_oe == 8'hFF)
      else $error("pins undriven");
   chk_lanes_bcd: assert property (o_out[3:0] < 4'hA && o_out[7:4] < 4'hA
      && o_bidir_out[3:0] < 4'hA && o_bidir_out[7:4] < 4'hA) else $error("not BCD");
   chk_lane_shift: assert property ($changed(lanes) && !$past(i_rst)
      |-> lanes[15:4] == $past(lanes[11:0])) else $error("no shift");
   chk_ce_freeze: assert property (!i_ce |=> $stable(lanes) && $stable(o_done))
      else $error("moved while disabled");
   chk_pause_freeze: assert property (i_pause |=> $stable(lanes))
      else $error("moved while paused");
   chk_done_hold: assert property (o_done && i_ce |=> o_done)
      else $error("done dropped");
   chk_lead_digit: assert property ($fell(i_rst) && i_ce && !i_pause
      |-> ##[1:4] o_bidir_out == 8'h02) else $error("no leading digit");
endmodule
bind e_digit_spigot_engine e_spigot_chk i_e_spigot_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_ce(i_ce), .i_pause(i_pause), .o_out(o_out), .o_bidir_out(o_bidir_out),
   .o_bidir_oe(o_bidir_oe), .o_done(o_done));

// ==== testbench/seg_display_model.sv ====
// Seven-segment display model behind the four BCD lanes.
`timescale 1ns/10ps
module seg_display_model (
   input wire logic i_core_clk,
   input wire logic i_hold,
   input wire logic [15:0] i_lanes,
   output logic o_pause,
   output logic [27:0] o_segs
);
   localparam logic [6:0] SEG [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
      7'h07, 7'h7F, 7'h6F};
   // A slow display stalls one edge after it is asked, as a latched ready would.
   always @(posedge i_core_clk) o_pause <= i_hold;
   for (genvar g = 0; g < 4; g++) begin : g_dec
      assign o_segs[g*7 +: 7] = (i_lanes[g*4 +: 4] < 4'hA) ? SEG[i_lanes[g*4 +: 4]] : 7'h00;
   end
endmodule

// ==== testbench/tb_e_digit_spigot_engine.sv ====
// Self-checking bench for the e digit spigot engine.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %0t %h %h", $time, g, e); end end
module tb_e_digit_spigot_engine;
   typedef struct packed {
      logic [3:0] dig;
      logic [7:0] stall;
   } row_type;
   localparam string E_TXT = "2718281828459045235360287471352";
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, hold = 1'b0;
   logic pause, done;
   logic [7:0] out_b, bidir_b, oe_b;
   logic [15:0] exp_l, prev_l, got;
   int n_fail = 0, checks_done = 0, cyc = 0, gap;
   row_type rows [31];
   wire [15:0] lanes = {out_b, bidir_b};
   always #5 clk = ~clk;
   e_digit_spigot_engine i_e_digit_spigot_engine (.i_core_clk(clk), .i_rst(rst), .i_ce(ce),
      .i_pause(pause), .o_out(out_b), .o_bidir_out(bidir_b), .o_bidir_oe(oe_b), .o_done(done));
   seg_display_model i_seg_display_model (.i_core_clk(clk), .i_hold(hold), .i_lanes(lanes),
      .o_pause(pause), .o_segs());
   task automatic finish_test();
      if (n_fail == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Waits for the lanes to move; after 300 edges a stuck engine counts as a mismatch.
   task automatic next_digit();
      gap = 0;
      while (lanes === prev_l && gap < 300) begin
         @(posedge clk);
         gap++;
      end
      if (gap >= 300) n_fail++;
      got = lanes;
      prev_l = lanes;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      foreach (rows[k]) begin
         rows[k].dig = 4'(E_TXT[k] - 8'h30);
         rows[k].stall = (k % 9 == 4) ? 8'h78 : 8'h00;
      end
      repeat (6) @(posedge clk);
      `CHK({lanes, oe_b, done}, 25'h0)
      rst <= 1'b0;
      exp_l = 16'h0000;
      prev_l = 16'h0000;
      // A long stall fills the buffer and blocks the engine; no digit may be lost.
      foreach (rows[k]) begin
         if (rows[k].stall != 8'h00) begin
            hold <= 1'b1;
            repeat (rows[k].stall) @(posedge clk);
            hold <= 1'b0;
         end
         next_digit();
         exp_l = {exp_l[11:0], rows[k].dig};
         // Thirty-two terms leave every digit of this build exact, so all are compared.
         `CHK(got, exp_l)
      end
      repeat (150) @(posedge clk);
      `CHK({done, oe_b, lanes}, {1'b1, 8'hFF, prev_l})
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK({lanes, oe_b, done}, 25'h0)
      rst <= 1'b0;
      prev_l = 16'h0000;
      next_digit();
      `CHK(got, 16'h0002)
      next_digit();
      `CHK({got, gap}, {16'h0027, 32'h21})
      ce <= 1'b0;
      repeat (60) @(posedge clk);
      `CHK(lanes, 16'h0027)
      ce <= 1'b1;
      next_digit();
      `CHK(got, 16'h0271)
      finish_test();
   end
endmodule
